//--- bsa_pkg.sv
// Shared constants and types for the burst SRAM access block.
`default_nettype none
package bsa_pkg;
	localparam int ADDR_WIDTH      = 18;
	localparam int BYTE_LANES      = 4;
	localparam int BYTE_WIDTH      = 8;
	localparam int LANE_WIDTH      = BYTE_WIDTH + 1;
	localparam int DATA_WIDTH      = BYTE_LANES * BYTE_WIDTH;
	localparam int WORD_WIDTH      = BYTE_LANES * LANE_WIDTH;
	localparam int BURST_WIDTH     = 2;
	localparam int BURST_POS       = 0;

	localparam int CLK_PERIOD_PS   = 100_000;
	localparam int CLK_TO_DATA_VALID_PS = 6_500;
	localparam int DATA_VALID_CYCLES =
		(CLK_TO_DATA_VALID_PS / CLK_PERIOD_PS) < 1 ? 1 :
		(CLK_TO_DATA_VALID_PS / CLK_PERIOD_PS);

	localparam logic                   MODE_LINEAR  = 1'h0;
	localparam logic                   MODE_RESET   = 1'h1;
	localparam logic [BURST_WIDTH-1:0] BURST_RESET  = 2'h0;
	localparam logic [BURST_WIDTH-1:0] BURST_STEP   = 2'h1;
	localparam logic [BYTE_LANES-1:0]  LANES_ALL    = 4'hF;
	localparam logic [BYTE_LANES-1:0]  LANES_NONE   = 4'h0;
	localparam logic [WORD_WIDTH-1:0]  WORD_RESET   = 36'h0_0000_0000;

	typedef enum logic {
		BSA_DESELECTED,
		BSA_ACTIVE
	} bsa_state_t;
endpackage
`default_nettype wire

//--- bsa_mem_if.sv
// Port bundle between the access control logic and its storage array.
`timescale 1ns/1ps
`default_nettype none
interface bsa_mem_if #(
	parameter int AW = bsa_pkg::ADDR_WIDTH
);
	logic [AW-1:0]                   addr;
	logic [bsa_pkg::BYTE_LANES-1:0]  wrLane;
	logic [bsa_pkg::WORD_WIDTH-1:0]  wrData;
	logic [bsa_pkg::WORD_WIDTH-1:0]  rdData;

	modport ctrl (
		output addr,
		output wrLane,
		output wrData,
		input  rdData
	);
	modport mem (
		input  addr,
		input  wrLane,
		input  wrData,
		output rdData
	);
endinterface
`default_nettype wire

//--- bsa_mem.sv
// Storage array with per-lane write and registered read data.
`timescale 1ns/1ps
`default_nettype none
module bsa_mem #(
	parameter int AW = bsa_pkg::ADDR_WIDTH
) (
	input  wire logic clock,
	input  wire logic rst_b,
	bsa_mem_if.mem    port
);
	localparam int DEPTH = 1 << AW;
	localparam int LW    = bsa_pkg::LANE_WIDTH;

	logic [bsa_pkg::WORD_WIDTH-1:0] store [0:DEPTH-1];
	logic [bsa_pkg::WORD_WIDTH-1:0] rdData_reg;

	// The array itself has no reset, as a real SRAM core would not.
	always_ff @(posedge clock) begin
		for (int i = 0; i < bsa_pkg::BYTE_LANES; i++) begin
			if (port.wrLane[i]) begin
				store[port.addr][i*LW +: LW] <= port.wrData[i*LW +: LW];
			end
		end
	end

	// Read returns the old word on a write edge; that cycle is not driven.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdData_reg <= bsa_pkg::WORD_RESET;
		end else begin
			rdData_reg <= store[port.addr];
		end
	end

	assign port.rdData = rdData_reg;
endmodule // bsa_mem
`default_nettype wire

//--- bsa_access_control.sv
// Flow-through burst SRAM access control with its storage array.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - All synchronous inputs are captured on the rising clock edge.
// - All chip selects active plus either strobe low starts an access.
// - Read data appear within one clock of the registering edge.
// - Processor strobe is ignored while chip_select1_n is high.
// - Processor-strobe start loads address, ignores write controls that cycle.
// - Write controls at the following edge then write the selected bytes.
// - Controller strobe with write controls writes in the start cycle.
// - Byte writes use lane selects; global write writes all four bytes.
// - Data and parity outputs float whenever a write is detected, except at a processor-strobe start.
// - Output enable gates the data drivers asynchronously.
// - Two-bit wraparound counter clears at each start and offsets address bits 1:0.
// - burst_step_n advances the burst whichever strobe started it.
// - Mode low gives linear order, high gives interleaved order.
// - With both strobes low and chip_select1_n low only the processor strobe counts.
// - Interleaved XORs the offset; linear adds it modulo four.
// - Write means global write low, or byte enable and a lane low.
// - Outputs float while deselected and until a new access starts.
module bsa_access_control #(
	parameter int AW = bsa_pkg::ADDR_WIDTH
) (
	input  wire logic                             clock,
	input  wire logic                             rst_b,
	input  wire logic [AW-1:0]                    address,
	input  wire logic                             chip_select1_n,
	input  wire logic                             chip_select2,
	input  wire logic                             chip_select3_n,
	input  wire logic                             processor_addr_strobe_n,
	input  wire logic                             controller_addr_strobe_n,
	input  wire logic                             burst_step_n,
	input  wire logic                             global_write_n,
	input  wire logic                             byte_write_enable_n,
	input  wire logic [bsa_pkg::BYTE_LANES-1:0]   byte_lane_select_n,
	input  wire logic                             output_enable_n,
	input  wire logic                             mode,
	input  wire logic [bsa_pkg::DATA_WIDTH-1:0]   dataIn,
	output logic      [bsa_pkg::DATA_WIDTH-1:0]   dataOut,
	output logic      [bsa_pkg::DATA_WIDTH-1:0]   dataOe,
	input  wire logic [bsa_pkg::BYTE_LANES-1:0]   parity_linesIn,
	output logic      [bsa_pkg::BYTE_LANES-1:0]   parity_linesOut,
	output logic      [bsa_pkg::BYTE_LANES-1:0]   parity_linesOe
);
	localparam int BW = bsa_pkg::BURST_WIDTH;
	localparam int LW = bsa_pkg::LANE_WIDTH;
	localparam int BL = bsa_pkg::BYTE_LANES;
	localparam int BY = bsa_pkg::BYTE_WIDTH;

	if (AW < BW || AW > 24) begin : g_bad_width
		$error("Address width must lie between 2 and 24 bits.");
	end
	if (bsa_pkg::DATA_VALID_CYCLES != 1) begin : g_bad_timing
		$error("Flow-through read must complete within one clock.");
	end
	if (bsa_pkg::WORD_WIDTH != BL * LW) begin : g_bad_word
		$error("Stored word must hold every lane with its parity bit.");
	end
	if (bsa_pkg::BURST_POS + BW > AW) begin : g_bad_burst
		$error("Burst bits must lie inside the address.");
	end

	// Burst address bits for a given offset from the first address.
	function automatic logic [BW-1:0] burstBits(
		input logic [BW-1:0] first,
		input logic [BW-1:0] offset,
		input logic          interleaved
	);
		logic [BW-1:0] result;
		result = BW'(first + offset);
		if (interleaved) begin
			result = first ^ offset;
		end
		return result;
	endfunction

	// Chip is selected only while all three selects are at their active level.
	function automatic logic chipSelected(
		input logic sel1N,
		input logic sel2,
		input logic sel3N
	);
		return !sel1N && sel2 && !sel3N;
	endfunction

	// Lanes that a write touches; an empty mask means the cycle is a read.
	function automatic logic [BL-1:0] writeMask(
		input logic          globalN,
		input logic          byteEnN,
		input logic [BL-1:0] laneN
	);
		logic [BL-1:0] lanes;
		lanes = bsa_pkg::LANES_NONE;
		if (!globalN) begin
			lanes = bsa_pkg::LANES_ALL;
		end else if (!byteEnN) begin
			lanes = ~laneN;
		end
		return lanes;
	endfunction

	// Burst offset after this edge: a low step input moves one place on.
	function automatic logic [BW-1:0] stepOffset(
		input logic [BW-1:0] offset,
		input logic          stepN
	);
		logic [BW-1:0] result;
		result = offset;
		if (!stepN) begin
			result = BW'(offset + bsa_pkg::BURST_STEP);
		end
		return result;
	endfunction

	bsa_pkg::bsa_state_t         state_reg;
	bsa_pkg::bsa_state_t         state_next;
	logic [AW-1:0]               addr_reg;
	logic [AW-1:0]               addr_next;
	logic [BW-1:0]               offset_reg;
	logic [BW-1:0]               offset_next;
	logic                        burstMode_reg;
	logic                        burstMode_next;
	logic                        drive_reg;
	logic                        drive_next;
	logic                        modeMeta_reg;
	logic                        modeSync_reg;

	logic                        chipEnabled;
	logic                        procStrobe;
	logic                        ctrlStrobe;
	logic                        writeSeen;
	logic [BL-1:0]               laneMask;
	logic                        startProc;
	logic                        startCtrl;
	logic                        deselect;
	logic                        continueBurst;
	logic                        startAny;
	logic                        driveEnable;
	logic [AW-1:0]               accessAddr;
	logic [BL-1:0]               writeLanes;
	logic [bsa_pkg::WORD_WIDTH-1:0] packedData;

	bsa_mem_if #(.AW(AW)) memPort ();

	bsa_mem #(
		.AW    (AW)
	) u_mem (
		.clock (clock),
		.rst_b (rst_b),
		.port  (memPort.mem)
	);

	// The strap is asynchronous to the bus, so it is synchronised first.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			modeMeta_reg <= bsa_pkg::MODE_RESET;
			modeSync_reg <= bsa_pkg::MODE_RESET;
		end else begin
			modeMeta_reg <= mode;
			modeSync_reg <= modeMeta_reg;
		end
	end

	// Decode of the pins as they stand before the capturing edge.
	always_comb begin
		chipEnabled = chipSelected(chip_select1_n, chip_select2,
			chip_select3_n);
		procStrobe  = !processor_addr_strobe_n && !chip_select1_n;
		ctrlStrobe  = !controller_addr_strobe_n && !procStrobe;
		writeSeen   = !global_write_n || (!byte_write_enable_n &&
			(byte_lane_select_n != bsa_pkg::LANES_ALL));
		laneMask    = writeMask(global_write_n, byte_write_enable_n,
			byte_lane_select_n);
		startProc     = procStrobe && chipEnabled;
		startCtrl     = ctrlStrobe && chipEnabled;
		startAny      = startProc || startCtrl;
		deselect      = (procStrobe || ctrlStrobe) && !chipEnabled;
		continueBurst = !procStrobe && !ctrlStrobe &&
			(state_reg == bsa_pkg::BSA_ACTIVE);
	end

	// Next access address, burst offset and data direction.
	always_comb begin
		state_next     = state_reg;
		addr_next      = addr_reg;
		offset_next    = offset_reg;
		burstMode_next = burstMode_reg;
		drive_next     = drive_reg;
		writeLanes     = bsa_pkg::LANES_NONE;
		case (state_reg)
			bsa_pkg::BSA_DESELECTED,
			bsa_pkg::BSA_ACTIVE: begin
				if (startAny) begin
					state_next     = bsa_pkg::BSA_ACTIVE;
					addr_next      = address;
					offset_next    = bsa_pkg::BURST_RESET;
					burstMode_next = modeSync_reg;
					if (startCtrl && writeSeen) begin
						writeLanes = laneMask;
						drive_next = 1'b0;
					end else begin
						drive_next = 1'b1;
					end
				end else if (deselect) begin
					state_next = bsa_pkg::BSA_DESELECTED;
					drive_next = 1'b0;
				end else if (continueBurst) begin
					offset_next = stepOffset(offset_reg, burst_step_n);
					if (writeSeen) begin
						writeLanes = laneMask;
						drive_next = 1'b0;
					end else begin
						drive_next = 1'b1;
					end
				end
			end
			default: begin
				state_next = bsa_pkg::BSA_DESELECTED;
				drive_next = 1'b0;
			end
		endcase
	end

	// The counter only reaches the two low bits; the rest stays latched.
	always_comb begin
		accessAddr = addr_next;
		accessAddr[bsa_pkg::BURST_POS +: BW] = burstBits(
			addr_next[bsa_pkg::BURST_POS +: BW], offset_next,
			burstMode_next != bsa_pkg::MODE_LINEAR);
	end

	always_comb begin
		for (int i = 0; i < BL; i++) begin
			packedData[i*LW +: LW] = {parity_linesIn[i], dataIn[i*BY +: BY]};
		end
	end

	// The array samples address, lanes and data at the same edge as the
	// input registers, which is what makes the read flow through.
	assign memPort.addr   = accessAddr;
	assign memPort.wrLane = writeLanes;
	assign memPort.wrData = packedData;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= bsa_pkg::BSA_DESELECTED;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_reg <= '0;
		end else begin
			addr_reg <= addr_next;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			offset_reg <= bsa_pkg::BURST_RESET;
		end else begin
			offset_reg <= offset_next;
		end
	end

	// Order is fixed per access, so a strap that moves cannot bend a burst.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			burstMode_reg <= bsa_pkg::MODE_RESET;
		end else begin
			burstMode_reg <= burstMode_next;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			drive_reg <= 1'b0;
		end else begin
			drive_reg <= drive_next;
		end
	end

	// Read data come straight from the array's output register.
	always_comb begin
		for (int i = 0; i < BL; i++) begin
			dataOut[i*BY +: BY] = memPort.rdData[i*LW +: BY];
			parity_linesOut[i]  = memPort.rdData[i*LW + BY];
		end
	end

	// Output enable is not sampled, so a bus master can turn the bus
	// around mid-cycle; it still cannot force drive during a write.
	assign driveEnable    = drive_reg && !output_enable_n;
	assign dataOe         = {bsa_pkg::DATA_WIDTH{driveEnable}};
	assign parity_linesOe = {BL{driveEnable}};
endmodule // bsa_access_control
`default_nettype wire

//--- bsa_access_props.sv
// Port-level timing checks for the burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module bsa_access_props (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        chip_select1_n,
	input wire logic        chip_select2,
	input wire logic        chip_select3_n,
	input wire logic        processor_addr_strobe_n,
	input wire logic        controller_addr_strobe_n,
	input wire logic        burst_step_n,
	input wire logic        global_write_n,
	input wire logic        byte_write_enable_n,
	input wire logic [3:0]  byte_lane_select_n,
	input wire logic        output_enable_n,
	input wire logic [31:0] dataOut,
	input wire logic [31:0] dataOe,
	input wire logic [3:0]  parity_linesOe
);
	logic en, wr, hold, pSt, off, on;
	assign en = !chip_select1_n && chip_select2 && !chip_select3_n;
	assign wr = !global_write_n || (!byte_write_enable_n &&
		byte_lane_select_n != 4'hF);
	assign hold = processor_addr_strobe_n && controller_addr_strobe_n;
	assign pSt = en && !processor_addr_strobe_n;
	assign off = dataOe == '0 && parity_linesOe == '0;
	assign on = output_enable_n || (&dataOe && &parity_linesOe);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_oe_gated: assert property (!off |-> !output_enable_n)
		else $error("drive while output enable high");
	a_oe_uniform: assert property (off || (&dataOe && &parity_linesOe))
		else $error("partial drive");
	a_ctrl_write: assert property (en && processor_addr_strobe_n &&
		!controller_addr_strobe_n && wr |=> off)
		else $error("drive after controller write");
	a_proc_write: assert property (pSt ##1 (hold && wr) |=> off)
		else $error("drive after processor write");
	a_proc_read: assert property (pSt |=> on)
		else $error("no drive after processor start");
	a_both_strobes: assert property (pSt && !controller_addr_strobe_n
		&& wr |=> on)
		else $error("controller strobe not overridden");
	a_deselect_off: assert property (!en && (!controller_addr_strobe_n ||
		(!processor_addr_strobe_n && !chip_select1_n)) |=> off)
		else $error("drive while deselected");
	a_hold_stable: assert property (pSt ##1 (hold && burst_step_n && !wr)
		|=> $stable(dataOut))
		else $error("data moved on burst hold");
	a_step_drive: assert property (pSt ##1 (hold && !burst_step_n && !wr)
		|=> on)
		else $error("no drive on burst step");
	c_step: cover property (pSt ##1 (hold && !burst_step_n));
	c_ctrl_wr: cover property (en && !controller_addr_strobe_n && wr);
	c_proc_wr: cover property (pSt ##1 (hold && wr));
endmodule // bsa_access_props
bind bsa_access_control bsa_access_props u_props (.clock, .rst_b,
	.chip_select1_n, .chip_select2, .chip_select3_n,
	.processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
	.global_write_n, .byte_write_enable_n, .byte_lane_select_n,
	.output_enable_n, .dataOut, .dataOe, .parity_linesOe);
`default_nettype wire

//--- bsa_bus_master.sv
// Bus master model that shares the data lines with the block.
`timescale 1ns/1ps
`default_nettype none
module bsa_bus_master (
	input  wire logic        clock,
	input  wire logic        drive,
	input  wire logic [31:0] wrData,
	input  wire logic [31:0] dataOut,
	input  wire logic [31:0] dataOe,
	output logic      [31:0] busData,
	output logic             clashSeen
);
	logic [31:0] lastBus = 32'h0000_0000;
	logic        clash;
	initial clashSeen = 1'b0;
	// A released bus shows the inverse of its last level, never a held copy.
	assign busData = drive ? wrData : (dataOe != '0 ? dataOut : ~lastBus);
	assign clash = drive && dataOe != '0;
	always @(posedge clock) begin
		lastBus <= busData;
	end
	always @(posedge clock) begin
		if (clash) begin
			clashSeen <= 1'b1;
		end
	end
endmodule // bsa_bus_master
`default_nettype wire

//--- burst_sram_access_control_tb.sv
// Self-checking bench for the burst SRAM access block.
`timescale 1ns/1ps
`default_nettype none
module burst_sram_access_control_tb;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic [5:0]  addr = 6'h00;
	logic        cs1N = 1'b0;
	logic        cs2 = 1'b1;
	logic        cs3N = 1'b0;
	logic        pAs = 1'b1;
	logic        cAs = 1'b1;
	logic        stepN = 1'b1;
	logic        gwN = 1'b1;
	logic        bweN = 1'b1;
	logic [3:0]  lanesN = 4'hF;
	logic        oeN = 1'b1;
	logic        mode = 1'b1;
	logic        drv = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0]  parIn = 4'h0;
	logic [31:0] bus, dOut, dOe;
	logic [3:0]  pOut, pOe;
	logic        clashSeen;
	int          mismatches = 0;
	int          tests_run = 0;
	always #50 clock = ~clock;
	bsa_access_control #(.AW(6)) dut (.clock(clock), .rst_b(rst_b),
		.address(addr), .chip_select1_n(cs1N), .chip_select2(cs2),
		.chip_select3_n(cs3N), .processor_addr_strobe_n(pAs),
		.controller_addr_strobe_n(cAs), .burst_step_n(stepN),
		.global_write_n(gwN), .byte_write_enable_n(bweN),
		.byte_lane_select_n(lanesN), .output_enable_n(oeN), .mode(mode),
		.dataIn(bus), .dataOut(dOut), .dataOe(dOe), .parity_linesIn(parIn),
		.parity_linesOut(pOut), .parity_linesOe(pOe));
	bsa_bus_master u_master (.clock(clock), .drive(drv), .wrData(wd),
		.dataOut(dOut), .dataOe(dOe), .busData(bus), .clashSeen(clashSeen));
	task automatic results();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] pat(input logic [5:0] a);
		return {4{2'h2, a}};
	endfunction
	// The master lifts output enable whenever it drives write data.
	task automatic cyc(input logic p, c, s, g, b, input logic [3:0] l,
			input logic [5:0] a, input logic [31:0] d);
		@(negedge clock);
		{pAs, cAs, stepN, gwN, bweN, lanesN, addr} = {p, c, s, g, b, l, a};
		drv = !g || (!b && l != 4'hF);
		oeN = drv;
		wd = d;
		parIn = d[3:0];
	endtask
	task automatic look(input logic [31:0] e);
		@(posedge clock);
		#10;
		chk({pOut, dOut}, {e[3:0], e});
		chk({pOe, dOe}, {36{!oeN}});
	endtask
	task automatic dark();
		@(posedge clock);
		#10;
		drv = 1'b0;
		oeN = 1'b0;
		#1 chk({pOe, dOe}, 36'h0_0000_0000);
	endtask
	task automatic t_burst(input logic m, input logic [1:0] f);
		logic [1:0] n;
		@(negedge clock) mode = m;
		repeat (3) cyc(1, 1, 1, 1, 1, 4'hF, addr, 0);
		cyc(0, 1, 1, 1, 1, 4'hF, {4'h4, f}, 0);
		look(pat({4'h4, f}));
		for (int i = 1; i < 4; i++) begin
			n = i[1:0];
			cyc(1, 1, 0, 1, 1, 4'hF, addr, 0);
			look(pat({4'h4, m ? f ^ n : f + n}));
		end
		cyc(1, 1, 1, 1, 1, 4'hF, addr, 0);
		look(pat({4'h4, m ? f ^ n : f + n}));
	endtask
	task automatic t_writes();
		cyc(0, 1, 1, 0, 1, 4'hF, 6'h20, 32'h1234_5678);
		cyc(1, 1, 1, 1, 1, 4'hF, 6'h20, 0);
		look(pat(6'h20));
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h21, 0);
		cyc(1, 1, 1, 0, 1, 4'hF, 6'h21, 32'h1234_5678);
		dark();
		cyc(1, 1, 1, 1, 1, 4'hF, 6'h21, 0);
		look(32'h1234_5678);
		cyc(1, 0, 1, 1, 0, 4'hA, 6'h10, 32'h1122_3344);
		dark();
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h10, 0);
		look(32'h9022_9044);
		cyc(1, 0, 1, 0, 0, 4'hE, 6'h11, 32'h5566_7788);
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h11, 0);
		look(32'h5566_7788);
		cyc(1, 0, 1, 1, 0, 4'hF, 6'h12, 0);
		look(pat(6'h12));
		cyc(0, 0, 1, 0, 1, 4'hF, 6'h13, 32'hFFFF_0000);
		cyc(1, 1, 1, 1, 1, 4'hF, 6'h13, 0);
		look(pat(6'h13));
	endtask
	task automatic t_select();
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h10, 0);
		look(32'h9022_9044);
		cyc(0, 1, 0, 1, 1, 4'hF, 6'h30, 0);
		cs1N = 1'b1;
		look(32'h5566_7788);
		cyc(1, 0, 1, 1, 1, 4'hF, 6'h10, 0);
		dark();
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h10, 0);
		dark();
		cyc(0, 1, 1, 1, 1, 4'hF, 6'h10, 0);
		cs1N = 1'b0;
		look(32'h9022_9044);
		oeN = 1'b1;
		#1 chk({pOe, dOe}, 36'h0_0000_0000);
		oeN = 1'b0;
		#1 chk({pOe, dOe}, 36'hF_FFFF_FFFF);
	endtask
	initial begin
		#200_000;
		mismatches++;
		results();
	end
	initial begin
		repeat (5) @(posedge clock);
		chk({pOe, dOe}, 36'h0_0000_0000);
		@(negedge clock) rst_b = 1'b1;
		for (int i = 16; i < 20; i++)
			cyc(1, 0, 1, 0, 1, 4'hF, i[5:0], pat(i[5:0]));
		cyc(1, 0, 1, 0, 1, 4'hF, 6'h20, pat(6'h20));
		dark();
		cyc(1, 1, 1, 1, 1, 4'hF, 6'h20, 0);
		look(pat(6'h20));
		for (int m = 0; m < 2; m++)
			for (int f = 0; f < 4; f++)
				t_burst(m[0], f[1:0]);
		t_writes();
		t_select();
		chk({35'h0, clashSeen}, 36'h0_0000_0000);
		results();
	end
endmodule // burst_sram_access_control_tb
`default_nettype wire
